// ### dsc_ahb.sv
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
module dsc_ahb
    import dsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    dsc_bus_if.slv bus
);
    logic pend_ff;
    logic write_ff;
    logic [7:0] addr_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic hresp_ff;
    logic accept;

    assign accept = hsel & htrans[1] & hready;

    // Wait state lets read data come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_ff <= 1'b0;
            write_ff <= 1'b0;
            addr_ff <= 8'h00;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= 32'h00000000;
        end else if (accept) begin
            pend_ff <= 1'b1;
            write_ff <= hwrite;
            addr_ff <= {haddr[7:2], 2'b00};
            hreadyout_ff <= 1'b0;
        end else if (pend_ff) begin
            pend_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= write_ff ? 32'h00000000 : bus.rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
        end
    end

    assign bus.wr = pend_ff & write_ff;
    assign bus.rd = pend_ff & ~write_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = hwdata;
    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = hresp_ff;
endmodule
`default_nettype wire

// ### dsc_bus_if.sv
// Register access strobes between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface dsc_bus_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slv (output wr, output rd, output addr, output wdata, input rdata);
    modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### dsc_dec_model.sv
// Decimator stand-in for the conversion sequencer testbench
`timescale 1ns/1ps
`default_nettype none
module dsc_dec_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dec_clr,
    input wire logic [3:0] insel,
    output logic [19:0] dec_data,
    output logic [7:0] clr_cnt
);
    // ------------------------------------------------------------
    // Result word and clear counter
    // ------------------------------------------------------------
    // Word carries the input number, so a sample from the old input is caught
    assign dec_data = {insel, 16'hc35a};
    // Counting clears shows whether the pipeline was primed again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clr_cnt <= 8'h00;
        end else if (dec_clr) begin
            clr_cnt <= clr_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### dsc_pkg.sv
// Shared constants and types for the delta-sigma conversion control block
package dsc_pkg;
    // ------------------------------------------------------------
    // Clock and conversion timing
    // ------------------------------------------------------------
    localparam int DSC_CLK_HZ = 20_000_000;
    localparam int DSC_SPS_20 = 187;
    localparam int DSC_SPS_16 = 48_000;
    localparam int DSC_SPS_12 = 192_000;
    localparam int DSC_SPS_8 = 384_000;
    localparam int DSC_PER_W = 24;
    // Highest rate gives least period: round up
    localparam int DSC_MIN_CYC_20 = (DSC_CLK_HZ + DSC_SPS_20 - 1) / DSC_SPS_20;
    localparam logic [23:0] DSC_MIN_CYC_16 = 24'((DSC_CLK_HZ + DSC_SPS_16 - 1) / DSC_SPS_16);
    localparam logic [23:0] DSC_MIN_CYC_12 = 24'((DSC_CLK_HZ + DSC_SPS_12 - 1) / DSC_SPS_12);
    localparam logic [23:0] DSC_MIN_CYC_8 = 24'((DSC_CLK_HZ + DSC_SPS_8 - 1) / DSC_SPS_8);
    localparam logic [4:0] DSC_RES_16 = 5'h10;
    localparam logic [4:0] DSC_RES_12 = 5'h0c;
    localparam logic [4:0] DSC_RES_8 = 5'h08;
    localparam logic [2:0] DSC_PRIME_N = 3'h3;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DSC_OFS_CTRL = 8'h00;
    localparam logic [7:0] DSC_OFS_STATUS = 8'h04;
    localparam logic [7:0] DSC_OFS_MASK = 8'h08;
    localparam logic [7:0] DSC_OFS_RESULT = 8'h0c;
    localparam logic [7:0] DSC_OFS_CFG = 8'h10;
    localparam logic [7:0] DSC_OFS_INSEL = 8'h14;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int DSC_CTRL_START = 0;
    localparam int DSC_CTRL_STOP = 1;
    localparam int DSC_CTRL_MODE = 2;
    localparam int DSC_CTRL_DONE = 4;
    localparam int DSC_CTRL_BUSY = 5;
    localparam int DSC_CFG_DIV = 8;
    localparam int DSC_STS_DONE = 0;
    localparam int DSC_STS_OVR = 1;
    localparam logic [4:0] DSC_RES_RST = 5'h10;
    localparam logic [23:0] DSC_DIV_RST = 24'h000000;
    localparam logic [1:0] DSC_MASK_RST = 2'h0;
    localparam logic [3:0] DSC_INSEL_RST = 4'h0;
    typedef enum logic [1:0] {
        DSC_MD_SINGLE = 2'b00,
        DSC_MD_MULTI = 2'b01,
        DSC_MD_CONT = 2'b10,
        DSC_MD_TURBO = 2'b11
    } dsc_mode_t;
    typedef enum logic {
        DSC_ST_IDLE = 1'b0,
        DSC_ST_RUN = 1'b1
    } dsc_state_t;
endpackage

// ### dsc_tick.sv
// Conversion timer: one pulse per finished conversion
`timescale 1ns/1ps
`default_nettype none
module dsc_tick
    import dsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic restart,
    input wire logic [DSC_PER_W-1:0] period,
    output logic tick
);
    logic [DSC_PER_W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (!run || restart) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff >= period - 24'h000001) begin
            cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 24'h000001;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

    AST_TICK_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !run |=> !tick) else $error("conversion finished while stopped");
endmodule
`default_nettype wire

// ### dsc_top.sv
// Delta-sigma conversion sequencer with AHB-Lite registers
//
// Function
// - Four modes: single, multi, continuous, turbo
// - Start by start bit or trigger
// - Done sets status, holds output until read
// - Single mode idles in standby until trigger
// - Four conversions per trigger, fourth valid
// - Back to standby after single result
// - Input change invalidates until fourth sample
// - Rate limit set by resolution, decimator
// - Continuous: three priming conversions, then each
// - Multi re-primes and restarts automatically
// - Turbo high resolution resets only once
`timescale 1ns/1ps
`default_nettype none
module dsc_top
    import dsc_pkg::*;
#(
    parameter int unsigned MIN_CYC_20 = DSC_MIN_CYC_20
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic soc_in,
    input wire logic [19:0] dec_data,
    output logic eoc,
    output logic dec_clr,
    output logic [3:0] insel,
    output logic busy,
    output logic irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dsc_bus_if bus ();
    dsc_state_t state_ff;
    dsc_state_t nxt_state;
    dsc_mode_t mode_ff;
    logic [4:0] res_ff;
    logic [23:0] div_ff;
    logic [3:0] insel_ff;
    logic [1:0] sts_ff;
    logic [1:0] mask_ff;
    logic [19:0] result_ff;
    logic [2:0] prime_ff;
    logic [2:0] smp_ff;
    logic eoc_ff;
    logic irq_ff;
    logic dec_clr_ff;
    logic soc_s1_ff;
    logic soc_s2_ff;
    logic soc_s3_ff;
    logic tick;
    logic start_req;
    logic stop_wr;
    logic rd_result;
    logic insel_chg;
    logic res_valid;
    logic reprime;
    logic clr_now;
    logic [23:0] min_per;
    logic [23:0] per_w;
    logic wr_ctrl;
    logic wr_sts;

    // ------------------------------------------------------------
    // Bus slave and conversion timer
    // ------------------------------------------------------------
    dsc_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .bus(bus.slv)
    );

    dsc_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        // Next state, so no tick lands in the first idle cycle after a stop
        .run(nxt_state == DSC_ST_RUN),
        .restart(clr_now),
        .period(per_w),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Decode and request logic
    // ------------------------------------------------------------
    assign wr_ctrl = bus.wr && (bus.addr == DSC_OFS_CTRL);
    assign wr_sts = bus.wr && (bus.addr == DSC_OFS_STATUS);
    assign stop_wr = wr_ctrl && bus.wdata[DSC_CTRL_STOP];
    assign rd_result = bus.rd && (bus.addr == DSC_OFS_RESULT);
    assign insel_chg = bus.wr && (bus.addr == DSC_OFS_INSEL) && (bus.wdata[3:0] != insel_ff);
    // Both sources in one cycle form one request
    assign start_req = (wr_ctrl && bus.wdata[DSC_CTRL_START]) || (soc_s2_ff && !soc_s3_ff);
    assign res_valid = tick && (prime_ff == DSC_PRIME_N);
    // Turbo at high resolution keeps the decimator primed between results
    assign reprime = res_valid && ((mode_ff == DSC_MD_MULTI) ||
        ((mode_ff == DSC_MD_TURBO) && (res_ff <= DSC_RES_16)));
    assign clr_now = ((state_ff == DSC_ST_IDLE) && start_req) || reprime || insel_chg;

    // Trigger comes from a pin: two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soc_s1_ff <= 1'b0;
            soc_s2_ff <= 1'b0;
            soc_s3_ff <= 1'b0;
        end else begin
            soc_s1_ff <= soc_in;
            soc_s2_ff <= soc_s1_ff;
            soc_s3_ff <= soc_s2_ff;
        end
    end

    // ------------------------------------------------------------
    // Conversion period
    // ------------------------------------------------------------
    // Divider can only slow the rate below the resolution limit
    always_comb begin
        if (res_ff > DSC_RES_16) begin
            min_per = 24'(MIN_CYC_20);
        end else if (res_ff > DSC_RES_12) begin
            min_per = DSC_MIN_CYC_16;
        end else if (res_ff > DSC_RES_8) begin
            min_per = DSC_MIN_CYC_12;
        end else begin
            min_per = DSC_MIN_CYC_8;
        end
        per_w = (div_ff > min_per) ? div_ff : min_per;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            DSC_ST_IDLE: begin
                if (start_req) begin
                    nxt_state = DSC_ST_RUN;
                end
            end
            DSC_ST_RUN: begin
                if (stop_wr || (res_valid && (mode_ff == DSC_MD_SINGLE))) begin
                    nxt_state = DSC_ST_IDLE;
                end
            end
            default: begin
                nxt_state = DSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= DSC_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Priming count: samples taken since the decimator was cleared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prime_ff <= 3'h0;
        end else if (clr_now) begin
            prime_ff <= 3'h0;
        end else if (tick && (prime_ff < DSC_PRIME_N)) begin
            prime_ff <= prime_ff + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_clr_ff <= 1'b0;
        end else begin
            dec_clr_ff <= clr_now;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ff <= 20'h00000;
        end else if (res_valid) begin
            result_ff <= dec_data;
        end
    end

    // Done output: a new result wins over a read in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eoc_ff <= 1'b0;
        end else if (res_valid) begin
            eoc_ff <= 1'b1;
        end else if (rd_result) begin
            eoc_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= DSC_MD_SINGLE;
            res_ff <= DSC_RES_RST;
            div_ff <= DSC_DIV_RST;
            insel_ff <= DSC_INSEL_RST;
            mask_ff <= DSC_MASK_RST;
        end else if (bus.wr) begin
            // Mode and rate fixed while converting
            if (wr_ctrl && (state_ff == DSC_ST_IDLE)) begin
                mode_ff <= dsc_mode_t'(bus.wdata[DSC_CTRL_MODE +: 2]);
            end
            if ((bus.addr == DSC_OFS_CFG) && (state_ff == DSC_ST_IDLE)) begin
                res_ff <= bus.wdata[4:0];
                div_ff <= bus.wdata[DSC_CFG_DIV +: 24];
            end
            if (bus.addr == DSC_OFS_INSEL) begin
                insel_ff <= bus.wdata[3:0];
            end
            if (bus.addr == DSC_OFS_MASK) begin
                mask_ff <= bus.wdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_ff <= 2'h0;
        end else begin
            sts_ff[DSC_STS_DONE] <= res_valid ||
                (sts_ff[DSC_STS_DONE] && !rd_result && !(wr_sts && bus.wdata[DSC_STS_DONE]));
            sts_ff[DSC_STS_OVR] <= (res_valid && eoc_ff && !rd_result) ||
                (sts_ff[DSC_STS_OVR] && !(wr_sts && bus.wdata[DSC_STS_OVR]));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(sts_ff & mask_ff);
        end
    end

    // Done is mirrored in the control register for polling
    always_comb begin
        case (bus.addr)
            DSC_OFS_CTRL: bus.rdata = {26'h0000000, (state_ff == DSC_ST_RUN), eoc_ff, mode_ff, 2'b00};
            DSC_OFS_STATUS: bus.rdata = {30'h00000000, sts_ff};
            DSC_OFS_MASK: bus.rdata = {30'h00000000, mask_ff};
            DSC_OFS_RESULT: bus.rdata = {12'h000, result_ff};
            DSC_OFS_CFG: bus.rdata = {div_ff, 3'b000, res_ff};
            DSC_OFS_INSEL: bus.rdata = {28'h0000000, insel_ff};
            default: bus.rdata = 32'h00000000;
        endcase
    end

    assign eoc = eoc_ff;
    assign dec_clr = dec_clr_ff;
    assign insel = insel_ff;
    assign busy = (state_ff == DSC_ST_RUN);
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Conversions counted since the decimator was last cleared (start, re-prime or input change)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_ff <= 3'h0;
        end else if (clr_now) begin
            smp_ff <= 3'h0;
        end else if (tick && (smp_ff != 3'h7)) begin
            smp_ff <= smp_ff + 3'h1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_START_RUN: assert property ((state_ff == DSC_ST_IDLE) && start_req |=> busy) else $error("start not taken");
    AST_IDLE_QUIET: assert property (!busy |-> !tick && !res_valid) else $error("work in standby");
    AST_EOC_SET: assert property (res_valid |=> eoc && sts_ff[0] && (result_ff == $past(dec_data))) else $error("done not raised");
    AST_EOC_HOLD: assert property (eoc && !rd_result && !res_valid |=> eoc) else $error("done dropped unread");
    AST_SINGLE_FOUR: assert property (res_valid && (mode_ff == DSC_MD_SINGLE) |-> smp_ff == 3'h3) else $error("not fourth conversion");
    AST_SINGLE_BACK: assert property (res_valid && (mode_ff == DSC_MD_SINGLE) |=> !busy [*2]) else $error("no return to standby");
    AST_INSEL_PRIME: assert property (insel_chg && !tick |=> prime_ff == 3'h0 && dec_clr) else $error("switch not reprimed");
    AST_RATE: assert property (busy |-> per_w >= DSC_MIN_CYC_8 && (res_ff <= DSC_RES_16 || per_w >= 24'(MIN_CYC_20))) else $error("rate too high");
    AST_CONT_NEXT: assert property (res_valid && (mode_ff == DSC_MD_CONT) && !stop_wr && !insel_chg |=> prime_ff == DSC_PRIME_N && busy) else $error("continuous lost priming");
    AST_MULTI_AGAIN: assert property (reprime && !stop_wr |=> busy && dec_clr && prime_ff == 3'h0) else $error("multi not restarted");
    AST_TURBO_HI: assert property (res_valid && (mode_ff == DSC_MD_TURBO) && (res_ff > DSC_RES_16) && !insel_chg |=> !dec_clr) else $error("turbo reset between samples");
    AST_READ_CLR: assert property (rd_result && !res_valid |=> !eoc && !sts_ff[0]) else $error("read did not clear");

    COV_SINGLE: cover property (res_valid && (mode_ff == DSC_MD_SINGLE) ##1 !busy);
    COV_MULTI: cover property (reprime ##[1:1000] res_valid);
    COV_CONT: cover property (res_valid && (mode_ff == DSC_MD_CONT) ##[1:1000] res_valid);
endmodule
`default_nettype wire

// ### dsc_top_tb.sv
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module dsc_top_tb;
    import dsc_pkg::*;
    localparam int MC20 = 64;
    localparam int P8 = 53;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic soc_in = 1'b0;
    logic hreadyout, hresp, eoc, dec_clr, busy, irq;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [3:0] insel;
    logic [19:0] dec_data;
    logic [7:0] clr_cnt;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc;
    int n;
    int cyc_now = 0;
    always @(posedge hclk) begin
        cyc_now <= cyc_now + 1;
    end
    initial begin
        forever #25 hclk = ~hclk;
    end
    dsc_top #(.MIN_CYC_20(MC20)) dsc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .soc_in(soc_in), .dec_data(dec_data),
        .eoc(eoc), .dec_clr(dec_clr), .insel(insel), .busy(busy), .irq(irq));
    dsc_dec_model dsc_dec_model_i (.hclk(hclk), .hresetn(hresetn), .dec_clr(dec_clr), .insel(insel),
        .dec_data(dec_data), .clr_cnt(clr_cnt));
    // ------------------------------------------------------------
    // Verdict and comparison
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic in_rng(input int v, input int lo, input int hi, input string what);
        chk(32'(v >= lo && v <= hi), 32'h1, what);
    endtask
    task automatic hang();
        n_mismatch++;
        $display("BAD t=%0t wait limit ran out", $time);
        tally_and_finish();
    endtask
    // ------------------------------------------------------------
    // AHB-Lite single word transfers
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) hang();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) hang();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask
    task automatic wait_eoc(output int c);
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (eoc !== 1'b1 && c < 5000);
        if (eoc !== 1'b1) hang();
    endtask
    // ------------------------------------------------------------
    // Running modes: first latency, spacing of results, re-priming
    // ------------------------------------------------------------
    task automatic run_gap(input dsc_mode_t md, input logic [31:0] cfg, input int p, input int lo, input int hi,
        input logic reprime, input logic [3:0] sel);
        logic [7:0] c0;
        int t0;
        wr(DSC_OFS_CFG, cfg);
        wr(DSC_OFS_CTRL, {28'h0, md, 2'b01});
        wait_eoc(cyc);
        // Spacing is timed from the last event that restarts the result stream
        c0 = clr_cnt;
        t0 = cyc_now;
        in_rng(cyc, 4 * p - 4, 4 * p + 8, "first result latency");
        rdc(DSC_OFS_RESULT, {12'h0, 4'h0, 16'hc35a}, "first result");
        rdc(DSC_OFS_CTRL, {26'h0, 2'b10, md, 2'b00}, "mode readback");
        wr(DSC_OFS_INSEL, {28'h0, sel});
        if (sel != 4'h0) begin
            t0 = cyc_now;
        end
        chk(insel, sel, "input select");
        wait_eoc(cyc);
        in_rng(cyc_now - t0, lo, hi, "spacing of results");
        chk(clr_cnt != c0, reprime, "decimator cleared between results");
        chk(busy, 1'b1, "still converting");
        wr(DSC_OFS_CTRL, 32'h2);
        rdc(DSC_OFS_RESULT, {12'h0, sel, 16'hc35a}, "second result");
        repeat (3) @(posedge hclk);
        chk(busy, 1'b0, "stopped");
        chk(eoc, 1'b0, "done cleared by read");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rdc(8'(4 * i), (i == 4) ? 32'h10 : 32'h0, "reset value or unmapped");
        end
        wr(DSC_OFS_MASK, 32'h1);
        wr(DSC_OFS_CFG, 32'h8);
        repeat (300) @(posedge hclk);
        chk(busy, 1'b0, "standby before start");
        wr(DSC_OFS_CTRL, 32'h1);
        chk(busy, 1'b1, "busy after start bit");
        wr(DSC_OFS_CTRL, 32'h1);
        wait_eoc(cyc);
        in_rng(cyc, 4 * P8 - 12, 4 * P8 + 8, "single result after four conversions");
        repeat (2) @(posedge hclk);
        chk(busy, 1'b0, "standby after result");
        chk(irq, 1'b1, "interrupt on done");
        rdc(DSC_OFS_STATUS, 32'h1, "done status");
        rdc(DSC_OFS_CTRL, 32'h10, "done in control");
        rdc(DSC_OFS_RESULT, {12'h0, 4'h0, 16'hc35a}, "single result");
        repeat (2) @(posedge hclk);
        chk(eoc, 1'b0, "done output released by read");
        chk(irq, 1'b0, "interrupt gone after read");
        rdc(DSC_OFS_STATUS, 32'h0, "status cleared by read");
        repeat (400) @(posedge hclk);
        chk({busy, eoc}, 2'b00, "no second single result");
        // Hardware trigger, completion found by polling
        soc_in <= 1'b1;
        repeat (4) @(posedge hclk);
        soc_in <= 1'b0;
        n = 0;
        do begin
            bus(1'b0, DSC_OFS_CTRL, 32'h0, rd);
            n++;
        end while (rd[DSC_CTRL_DONE] !== 1'b1 && n < 200);
        chk(rd, 32'h10, "trigger gives result seen by polling");
        wr(DSC_OFS_STATUS, 32'h1);
        rdc(DSC_OFS_STATUS, 32'h0, "status write one clears");
        chk({eoc, irq}, 2'b10, "done output holds until read");
        wr(DSC_OFS_MASK, 32'h0);
        rdc(DSC_OFS_RESULT, {12'h0, 4'h0, 16'hc35a}, "triggered result");
        run_gap(DSC_MD_MULTI, 32'h8, P8, 3 * P8, 4 * P8 + 8, 1'b1, 4'h0);
        run_gap(DSC_MD_CONT, 32'h8, P8, P8 - 8, P8 + 4, 1'b0, 4'h0);
        run_gap(DSC_MD_TURBO, 32'h8, P8, 3 * P8, 4 * P8 + 8, 1'b1, 4'h0);
        run_gap(DSC_MD_TURBO, 32'h14, MC20, MC20 - 8, MC20 + 4, 1'b0, 4'h0);
        run_gap(DSC_MD_CONT, 32'h6408, 100, 92, 104, 1'b0, 4'h0);
        run_gap(DSC_MD_CONT, 32'h8, P8, 3 * P8, 4 * P8 + 8, 1'b1, 4'h5);
        tally_and_finish();
    end
endmodule
`default_nettype wire
